// File: dtg_ctrl.sv
// power mode controller: direct transfers and peripheral clock gates
`include "dtg_defs.svh"
module dtg_ctrl
  import dtg_pkg::*;
#(
  parameter int WAIT_UNIT = 1024
)
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sleep_exec,
  input  wire logic        wake_event,
  output logic             cpu_state_tick,
  output logic             cpu_halted,
  output logic [1:0]       run_mode,
  output logic             dt_irq,
  output logic [6:0]       gate_one_en,
  output logic [3:0]       gate_two_en,
  output logic             irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  dtg_sysctl_s sysctl_q, sysctl_d;
  logic [7:0]  gate_one_q, gate_one_d;
  logic [7:0]  gate_two_q, gate_two_d;
  logic [1:0]  stat_q, stat_d;
  logic [1:0]  mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  dtg_state_e  st_q, st_d;
  dtg_mode_e   mode_q, mode_d, tgt_q, tgt_d;
  logic [20:0] cnt_q, cnt_d;
  logic        dtirq_q, dtirq_d;
  logic        halt_q, halt_d;
  logic        tick_out_q, tick_out_d;
  logic        irq_q, irq_d;
  logic [7:0]  div;
  logic        tick;
  logic        done_ev;
  logic        halt_ev;

  function automatic logic [20:0] wait_states(input logic [2:0] sel);
    wait_states = 21'(WAIT_UNIT) << sel;
  endfunction

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then acknowledge
  // ----------------------------------------------------------------
  always_comb
  begin
    sysctl_d   = sysctl_q;
    gate_one_d = gate_one_q;
    gate_two_d = gate_two_q;
    mask_d     = mask_q;
    stat_d     = stat_q | {halt_ev, done_ev};
    rdata_d    = 32'h0000_0000;
    ack_d      = (avs_read | avs_write) & ~ack_q;
    if (avs_write && ack_q)
    begin
      unique case (avs_address)
        `DTG_OFS_SYSCTL:   sysctl_d   = dtg_sysctl_s'(avs_writedata[10:0]);
        `DTG_OFS_GATE_ONE: gate_one_d = avs_writedata[7:0];
        `DTG_OFS_GATE_TWO: gate_two_d = avs_writedata[7:0];
        `DTG_OFS_IRQ_STAT:
          stat_d = (stat_q & ~avs_writedata[1:0]) | {halt_ev, done_ev};
        `DTG_OFS_IRQ_MASK: mask_d = avs_writedata[1:0];
        default: ;
      endcase
    end
    if (avs_read && !ack_q)
    begin
      unique case (avs_address)
        `DTG_OFS_SYSCTL:   rdata_d = {21'h0, sysctl_q};
        `DTG_OFS_GATE_ONE: rdata_d = {24'h0, gate_one_q};
        `DTG_OFS_GATE_TWO: rdata_d = {24'h0, gate_two_q};
        `DTG_OFS_IRQ_STAT: rdata_d = {30'h0, stat_q};
        `DTG_OFS_IRQ_MASK: rdata_d = {30'h0, mask_q};
        `DTG_OFS_MODE:     rdata_d = {27'h0, st_q, mode_q};
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
    else if (ack_q)
      rdata_d = rdata_q;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sysctl_q   <= dtg_sysctl_s'(`DTG_SYSCTL_RESET);
      gate_one_q <= `DTG_GATE_RESET;
      gate_two_q <= `DTG_GATE_RESET;
      stat_q     <= 2'h0;
      mask_q     <= 2'h0;
      rdata_q    <= 32'h0000_0000;
      ack_q      <= 1'b0;
      irq_q      <= 1'b0;
    end
    else
    begin
      sysctl_q   <= sysctl_d;
      gate_one_q <= gate_one_d;
      gate_two_q <= gate_two_d;
      stat_q     <= stat_d;
      mask_q     <= mask_d;
      rdata_q    <= rdata_d;
      ack_q      <= ack_d;
      irq_q      <= irq_d;
    end
  end

  assign avs_waitrequest = ~ack_q;
  assign avs_readdata    = rdata_q;
  assign irq             = irq_q;

  // ----------------------------------------------------------------
  // cpu rate: divisor follows the mode, which changes one or two clocks after a state tick
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (mode_q)
      DTG_MODE_HIGH: div = 8'h01;
      DTG_MODE_MED:  div = `DTG_MED_DIV;
      DTG_MODE_SUB:  div = `DTG_SUB_DIV;
      default:       div = 8'h01;
    endcase
  end

  dtg_rate_div u_div
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .div     (div),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d    = st_q;
    mode_d  = mode_q;
    tgt_d   = tgt_q;
    cnt_d   = cnt_q;
    dtirq_d = 1'b0;
    halt_d  = halt_q;
    done_ev = 1'b0;
    halt_ev = 1'b0;
    unique case (st_q)
      DTG_ST_RUN:
        if (sleep_exec)
        begin
          cnt_d = 21'(`DTG_SLEEP_STATES + `DTG_INTPROC_STATE);
          st_d  = DTG_ST_PRE;
          if (!sysctl_q.dt_en || !sysctl_q.dt_irq_en)
          begin
            st_d    = DTG_ST_HALT;
            halt_d  = 1'b1;
            halt_ev = 1'b1;
          end
          else if (mode_q != DTG_MODE_SUB && sysctl_q.stby_sel &&
                   sysctl_q.low_sel && sysctl_q.watch_clk)
            tgt_d = DTG_MODE_SUB;
          else if (mode_q == DTG_MODE_HIGH && !sysctl_q.stby_sel &&
                   !sysctl_q.low_sel && sysctl_q.med_sel)
            tgt_d = DTG_MODE_MED;
          else if (mode_q == DTG_MODE_MED && !sysctl_q.stby_sel &&
                   !sysctl_q.low_sel && !sysctl_q.med_sel)
            tgt_d = DTG_MODE_HIGH;
          else if (mode_q == DTG_MODE_SUB && sysctl_q.stby_sel &&
                   !sysctl_q.low_sel && sysctl_q.watch_clk)
            tgt_d = sysctl_q.med_sel ? DTG_MODE_MED
                                     : DTG_MODE_HIGH;
          else
          begin
            st_d    = DTG_ST_HALT;
            halt_d  = 1'b1;
            halt_ev = 1'b1;
          end
        end
      DTG_ST_PRE:
        if (tick)
        begin
          if (cnt_q > 21'h1)
            cnt_d = cnt_q - 21'h1;
          else if ((mode_q == DTG_MODE_SUB) != (tgt_q == DTG_MODE_SUB))
            st_d = DTG_ST_WATCH;
          else
          begin
            mode_d = tgt_q;
            cnt_d  = 21'(`DTG_EXC_STATES);
            st_d   = DTG_ST_EXC;
            dtirq_d = 1'b1;
          end
        end
      DTG_ST_WATCH:
      begin
        mode_d = tgt_q;
        if (mode_q == DTG_MODE_SUB)
        begin
          cnt_d = wait_states(sysctl_q.wait_sel);
          st_d  = DTG_ST_SETL;
        end
        else
        begin
          cnt_d   = 21'(`DTG_EXC_STATES);
          st_d    = DTG_ST_EXC;
          dtirq_d = 1'b1;
        end
      end
      DTG_ST_SETL:
        if (tick)
        begin
          if (cnt_q > 21'h1)
            cnt_d = cnt_q - 21'h1;
          else
          begin
            cnt_d   = 21'(`DTG_EXC_STATES);
            st_d    = DTG_ST_EXC;
            dtirq_d = 1'b1;
          end
        end
      DTG_ST_EXC:
        if (tick)
        begin
          if (cnt_q > 21'h1)
            cnt_d = cnt_q - 21'h1;
          else
          begin
            st_d    = DTG_ST_RUN;
            done_ev = 1'b1;
          end
        end
      DTG_ST_HALT:
        if (wake_event)
        begin
          halt_d = 1'b0;
          st_d   = DTG_ST_RUN;
        end
      default: st_d = DTG_ST_RUN;
    endcase
    // state tick leaves through a flop and stays quiet while halted
    tick_out_d = tick & ~halt_d;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_q    <= DTG_ST_RUN;
      mode_q  <= DTG_MODE_MED;
      tgt_q   <= DTG_MODE_MED;
      cnt_q   <= 21'h0;
      dtirq_q <= 1'b0;
      halt_q  <= 1'b0;
      tick_out_q <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      mode_q  <= mode_d;
      tgt_q   <= tgt_d;
      cnt_q   <= cnt_d;
      dtirq_q <= dtirq_d;
      halt_q  <= halt_d;
      tick_out_q <= tick_out_d;
    end
  end

  assign cpu_state_tick = tick_out_q;
  assign cpu_halted     = halt_q;
  assign run_mode       = mode_q;
  assign dt_irq         = dtirq_q;

  // ----------------------------------------------------------------
  // peripheral clock gates, registered per branch
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_one
      dtg_clk_gate u_gate
      (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .gate_on (gate_one_q[gi]),
        .clk_en  (gate_one_en[gi])
      );
    end
    for (gi = 0; gi < 4; gi++)
    begin : g_two
      dtg_clk_gate u_gate
      (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .gate_on (gate_two_q[gi]),
        .clk_en  (gate_two_en[gi])
      );
    end
  endgenerate

endmodule

// File: dtg_defs.svh
// constants for the direct-transfer and module clock gating block
`ifndef DTG_DEFS_SVH
`define DTG_DEFS_SVH

// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define DTG_OFS_SYSCTL    4'h0
`define DTG_OFS_GATE_ONE  4'h1
`define DTG_OFS_GATE_TWO  4'h2
`define DTG_OFS_IRQ_STAT  4'h3
`define DTG_OFS_IRQ_MASK  4'h4
`define DTG_OFS_MODE      4'h5

// ----------------------------------------------------------------
// system control field positions
// ----------------------------------------------------------------
`define DTG_BIT_STBY      0
`define DTG_BIT_LOWSPD    1
`define DTG_BIT_MEDSPD    2
`define DTG_BIT_DTEN      3
`define DTG_BIT_WCLK      4
`define DTG_BIT_DTIE      5
`define DTG_WAIT_LSB      8
`define DTG_WAIT_MSB      10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DTG_GATE_RESET    8'hFF
`define DTG_SYSCTL_RESET  11'h020

// ----------------------------------------------------------------
// timing counts in cpu states and cpu rate divisors
// ----------------------------------------------------------------
`define DTG_SLEEP_STATES  8'h02
`define DTG_INTPROC_STATE 8'h01
`define DTG_EXC_STATES    8'h0E
`define DTG_MED_DIV       8'h08
`define DTG_SUB_DIV       8'h10

`endif

// File: dtg_pkg.sv
// types for the direct-transfer and module clock gating block
package dtg_pkg;

  typedef enum logic [1:0] {
    DTG_MODE_HIGH = 2'b00,
    DTG_MODE_MED  = 2'b01,
    DTG_MODE_SUB  = 2'b10
  } dtg_mode_e;

  typedef struct packed {
    logic [2:0] wait_sel;
    logic [1:0] rsvd;
    logic       dt_irq_en;
    logic       watch_clk;
    logic       dt_en;
    logic       med_sel;
    logic       low_sel;
    logic       stby_sel;
  } dtg_sysctl_s;

  typedef enum logic [2:0] {
    DTG_ST_RUN   = 3'b000,
    DTG_ST_PRE   = 3'b001,
    DTG_ST_WATCH = 3'b010,
    DTG_ST_SETL  = 3'b011,
    DTG_ST_EXC   = 3'b100,
    DTG_ST_HALT  = 3'b101
  } dtg_state_e;

endpackage

// File: dtg_clk_gate.sv
// glitch-free latch-free clock enable gate for one branch
module dtg_clk_gate
  import dtg_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic gate_on,
  output logic      clk_en
);

  logic en_q;
  logic en_d;

  // enable changes only on a clock edge, so no pulse is shortened
  always_comb
  begin
    en_d = gate_on;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      en_q <= 1'b1;
    else
      en_q <= en_d;
  end

  assign clk_en = en_q;

endmodule

// File: dtg_rate_div.sv
// cpu clock rate divider giving one tick per cpu state
module dtg_rate_div
  import dtg_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [7:0] div,
  output logic            tick
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       tick_q;
  logic       tick_d;

  // new divisor takes effect at once against the running count: no state shorter than it
  always_comb
  begin
    tick_d = (cnt_q >= div - 8'h01);
    cnt_d  = tick_d ? 8'h00 : cnt_q + 8'h01;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// File: dtg_ctrl_properties.sv
// port assertions for the direct-transfer and clock gating controller
`include "dtg_defs.svh"
module dtg_ctrl_props
  import dtg_pkg::*;
#(
  parameter int WAIT_UNIT = 1024
)
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        sleep_exec,
  input wire logic        wake_event,
  input wire logic        cpu_state_tick,
  input wire logic        cpu_halted,
  input wire logic [1:0]  run_mode,
  input wire logic        dt_irq,
  input wire logic [6:0]  gate_one_en,
  input wire logic [3:0]  gate_two_en,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic [9:0] since_q;
  logic [9:0] since_d;

  // ------------------------------
  // cycles since the last sleep
  // ------------------------------
  always_comb
  begin
    since_d = since_q;
    if (sleep_exec)
      since_d = 10'h000;
    else if (since_q != 10'h3FF)
      since_d = since_q + 10'h001;
  end
  always_ff @(posedge clk_sys)
    since_q <= sys_rst ? 10'h3FF : since_d;

  // ------------------------------
  // assertions
  // ------------------------------
  a_gate_one_follow:
    assert property (avs_write && !avs_waitrequest
      && avs_address == `DTG_OFS_GATE_ONE
      |-> ##2 gate_one_en == $past(avs_writedata[6:0], 2))
    else $error("gate one enables do not follow the register");
  a_gate_two_follow:
    assert property (avs_write && !avs_waitrequest
      && avs_address == `DTG_OFS_GATE_TWO
      |-> ##2 gate_two_en == $past(avs_writedata[3:0], 2))
    else $error("gate two enables do not follow the register");
  a_reset_all_on:
    assert property (disable iff (1'b0) sys_rst |=> gate_one_en == 7'h7F
      && gate_two_en == 4'hF && run_mode == DTG_MODE_MED && !irq)
    else $error("reset state wrong");
  a_mode_by_sleep:
    assert property (!$stable(run_mode) |-> since_q < 10'h3E8)
    else $error("run mode changed without a sleep");
  a_dt_irq_pulse:
    assert property (dt_irq |=> !dt_irq)
    else $error("transfer interrupt longer than one cycle");
  a_halt_quiet:
    assert property (cpu_halted |-> !dt_irq)
    else $error("transfer interrupt while halted");
  a_wait_answer:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_single:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held too long");
endmodule

bind dtg_ctrl dtg_ctrl_props #(.WAIT_UNIT(WAIT_UNIT)) chk_u (.clk_sys,
  .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .sleep_exec, .wake_event,
  .cpu_state_tick, .cpu_halted, .run_mode, .dt_irq, .gate_one_en,
  .gate_two_en, .irq);

// File: dtg_cpu_model.sv
// cpu-side model issuing sleep and wake pulses
module dtg_cpu_model
(
  input  wire logic clk_sys,
  output logic      sleep_exec,
  output logic      wake_event
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sleep_exec = 1'b0;
    wake_event = 1'b0;
  end
  // one-cycle pulse: wake when wk is set, else sleep
  task automatic pulse(input logic wk);
    @(posedge clk_sys);
    wake_event <= wk;
    sleep_exec <= !wk;
    @(posedge clk_sys);
    wake_event <= 1'b0;
    sleep_exec <= 1'b0;
  endtask
endmodule

// File: dtg_ctrl_test.sv
// self-checking bench for the direct-transfer and clock gating controller
`include "dtg_defs.svh"
module dtg_ctrl_test
  import dtg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sleep_exec;
  logic        wake_event;
  logic        cpu_state_tick;
  logic        cpu_halted;
  logic [1:0]  run_mode;
  logic        dt_irq;
  logic [6:0]  gate_one_en;
  logic [3:0]  gate_two_en;
  logic        irq;
  logic [31:0] q;
  int          n_errors = 0;
  int          checked = 0;

  always #4 clk_sys = ~clk_sys;

  dtg_ctrl #(.WAIT_UNIT(2)) dut_u (.clk_sys, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .sleep_exec, .wake_event, .cpu_state_tick,
    .cpu_halted, .run_mode, .dt_irq, .gate_one_en, .gate_two_en, .irq);
  dtg_cpu_model cpu_u (.clk_sys, .sleep_exec, .wake_event);

  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic print_verdict();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_for(ref logic s, input logic v, input int lim,
                          output int n);
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
      if (n > lim)
      begin
        cmp(32'h0, 32'h1);
        print_verdict();
      end
    end
    while (s !== v);
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (n > 50)
      begin
        cmp(32'h0, 32'h1);
        print_verdict();
      end
    end
    while (avs_waitrequest !== 1'b0);
    // take data and release at the edge that sees waitrequest low
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(q, exp);
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_gates();
    bus(1'b1, `DTG_OFS_GATE_ONE, 32'h5A);
    bus(1'b1, `DTG_OFS_GATE_TWO, 32'hF5);
    bus(1'b1, 4'hF, 32'h12);
    rdc(4'hF, 32'h0);
    rdc(`DTG_OFS_GATE_ONE, 32'h5A);
    rdc(`DTG_OFS_GATE_TWO, 32'hF5);
    @(negedge clk_sys);
    cmp(32'(gate_one_en), 32'h5A);
    cmp(32'(gate_two_en), 32'h5);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdc(`DTG_OFS_GATE_ONE, 32'hFF);
    rdc(`DTG_OFS_GATE_TWO, 32'hFF);
    cmp(32'({gate_one_en, gate_two_en}), 32'h7FF);
    $display("gates test done");
  endtask

  task automatic xfer(input logic [31:0] ctl, input logic [1:0] m,
                      input int lo);
    int n;
    bus(1'b1, `DTG_OFS_SYSCTL, ctl);
    cpu_u.pulse(1'b0);
    wait_for(dt_irq, 1'b1, 3000, n);
    cmp(32'(n >= lo), 32'h1);
    repeat (250) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp(32'(run_mode), 32'(m));
    $display("transfer to mode %0d done", m);
  endtask

  task automatic t_irq();
    logic a;
    rdc(`DTG_OFS_IRQ_STAT, 32'h1);
    bus(1'b1, `DTG_OFS_IRQ_MASK, 32'h1);
    repeat (2) @(negedge clk_sys);
    a = irq;
    bus(1'b1, `DTG_OFS_IRQ_MASK, 32'h0);
    repeat (2) @(negedge clk_sys);
    cmp(32'(a ^ irq), 32'h1);
    bus(1'b1, `DTG_OFS_IRQ_STAT, 32'h1);
    rdc(`DTG_OFS_IRQ_STAT, 32'h0);
    repeat (2) @(negedge clk_sys);
    cmp(32'(irq), 32'h0);
    $display("interrupt test done");
  endtask

  task automatic t_halt();
    int n;
    bus(1'b1, `DTG_OFS_SYSCTL, 32'h0C);
    cpu_u.pulse(1'b0);
    wait_for(cpu_halted, 1'b1, 500, n);
    cmp(32'(cpu_state_tick), 32'h0);
    cpu_u.pulse(1'b1);
    wait_for(cpu_halted, 1'b0, 100, n);
    rdc(`DTG_OFS_IRQ_STAT, 32'h2);
    $display("halt test done");
  endtask

  initial
  begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdc(`DTG_OFS_SYSCTL, 32'h20);
    t_gates();
    xfer(32'h28, DTG_MODE_HIGH, 16);
    xfer(32'h2C, DTG_MODE_MED, 2);
    xfer(32'h3B, DTG_MODE_SUB, 16);
    xfer(32'h239, DTG_MODE_HIGH, 40);
    xfer(32'h3B, DTG_MODE_SUB, 2);
    xfer(32'h23D, DTG_MODE_MED, 88);
    t_irq();
    t_halt();
    print_verdict();
  end
endmodule
